// >>> rtl/hth_pkg.sv
// package: constants and types for the host transfer handshake
package hth_pkg;

  // ==========================================================
  // widths
  localparam int HTH_DATA_W = 16;
  localparam int HTH_ADDR_W = 16;

  // ==========================================================
  // timing
  localparam int HTH_CLK_MHZ          = 40;
  localparam int HTH_ACCESS_NS        = 100;  // internal access time
  localparam int HTH_ACCESS_CYC_RAW   = (HTH_ACCESS_NS * HTH_CLK_MHZ + 999) / 1000;
  localparam int HTH_ACCESS_CYC       = (HTH_ACCESS_CYC_RAW < 1) ? 1 : HTH_ACCESS_CYC_RAW;
  localparam int HTH_CNT_W            = 4;

  // ==========================================================
  // reset values
  localparam logic        HTH_READY_N_RST = 1'b1;
  localparam logic        HTH_IO_BUFFER_ENABLE_N_N_RST  = 1'b1;
  localparam logic        HTH_STROBE_RST  = 1'b1;
  localparam logic [15:0] HTH_DATA_RST    = 16'h0000;

  // ==========================================================
  // states
  typedef enum logic [2:0] {
    HTH_IDLE,
    HTH_ACCESS,
    HTH_DONE,
    HTH_RELEASE
  } hth_state_t;

endpackage : hth_pkg

// >>> rtl/hth_if.sv
// interface: host port pins between terminal and host
`timescale 1ns/1ps
`default_nettype none
interface hth_if;
  import hth_pkg::*;
  logic                    host_strobe_n;
  logic                    host_ready_n;
  logic                    io_buffer_enable_n;
  logic                    mem_reg_sel;
  logic                    rd_wr;
  logic                    transparent_mode;
  logic [HTH_ADDR_W-1:0]   addr;
  logic [HTH_DATA_W-1:0]   data_h2d;
  logic                    data_h2d_oe;
  logic [HTH_DATA_W-1:0]   data_d2h;
  logic                    data_d2h_oe;
  logic [HTH_DATA_W-1:0]   data_bus;

  // resolved data bus from output enables
  assign data_bus = data_d2h_oe ? data_d2h : (data_h2d_oe ? data_h2d : '0);

  modport device (
    input  host_strobe_n, mem_reg_sel, rd_wr, transparent_mode, addr, data_bus,
    output host_ready_n, io_buffer_enable_n, data_d2h, data_d2h_oe
  );
  modport host (
    input  host_ready_n, io_buffer_enable_n, data_bus,
    output host_strobe_n, mem_reg_sel, rd_wr, transparent_mode, addr, data_h2d, data_h2d_oe
  );
endinterface : hth_if
`default_nettype wire

// >>> rtl/hth_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hth_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // data
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta <= RST;
      dout <= RST;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : hth_sync
`default_nettype wire

// >>> rtl/hth_device.sv
// device end: ready handshake and buffer enable of the terminal host port
`timescale 1ns/1ps
`default_nettype none
module hth_device (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // pins
  hth_if.device                   pins,
  // user side: register file
  output logic [hth_pkg::HTH_ADDR_W-1:0] reg_addr,
  output logic [hth_pkg::HTH_DATA_W-1:0] reg_wdata,
  output logic                    reg_wr,
  output logic                    reg_rd,
  output logic                    reg_mem_sel,
  input  wire logic [hth_pkg::HTH_DATA_W-1:0] reg_rdata,
  output logic                    busy
);
  import hth_pkg::*;

  // ==========================================================
  // input synchronisation
  logic                    strobe_n_s;
  logic                    mode_s;
  logic                    sel_s;
  logic                    rdwr_s;
  logic [HTH_ADDR_W-1:0]   addr_s;
  logic [HTH_DATA_W-1:0]   data_s;

  hth_sync #(.W(1), .RST(HTH_STROBE_RST)) u_sync_strb (
    .sys_clk(sys_clk), .srst(srst), .din(pins.host_strobe_n), .dout(strobe_n_s));
  hth_sync #(.W(1), .RST(1'b0)) u_sync_mode (
    .sys_clk(sys_clk), .srst(srst), .din(pins.transparent_mode), .dout(mode_s));
  hth_sync #(.W(1), .RST(1'b0)) u_sync_sel (
    .sys_clk(sys_clk), .srst(srst), .din(pins.mem_reg_sel), .dout(sel_s));
  hth_sync #(.W(1), .RST(1'b1)) u_sync_rw (
    .sys_clk(sys_clk), .srst(srst), .din(pins.rd_wr), .dout(rdwr_s));
  hth_sync #(.W(HTH_ADDR_W), .RST('0)) u_sync_addr (
    .sys_clk(sys_clk), .srst(srst), .din(pins.addr), .dout(addr_s));
  hth_sync #(.W(HTH_DATA_W), .RST('0)) u_sync_data (
    .sys_clk(sys_clk), .srst(srst), .din(pins.data_bus), .dout(data_s));

  // ==========================================================
  // state and decode
  // idle, then access for the counted internal access time, then
  // done (nonzero-wait: ready low until the strobe is released) or
  // release (zero-wait: ready already high again, waiting for the
  // strobe to go away so that one strobe never starts two accesses);
  // a strobe that falls while busy is not seen until idle
  hth_state_t              state;
  hth_state_t              next_state;
  logic [HTH_CNT_W-1:0]    cnt;
  logic [HTH_CNT_W-1:0]    next_cnt;
  logic                    is_read;
  logic                    zero_wait;
  logic                    start;
  logic                    acc_end;
  logic                    next_access;
  logic                    next_done;
  logic                    next_release;
  logic                    next_busy;
  logic                    next_ready_n;
  logic                    next_io_buffer_enable_n_n;
  logic                    next_d2h_oe;
  logic                    next_wr;
  logic                    next_rd;
  logic                    ready_n_q;
  logic                    io_buffer_enable_n_n_q;
  logic [HTH_DATA_W-1:0]   rdata_q;
  logic                    d2h_oe_q;

  // state match, shared by current and next state decoding
  function automatic logic state_is(input hth_state_t s, input hth_state_t want);
    return (s == want);
  endfunction

  // request decode from the synchronised pins
  assign is_read   = rdwr_s;
  assign zero_wait = ~mode_s;   // buffered strap means zero-wait
  assign start     = state_is(state, HTH_IDLE) && !strobe_n_s;
  // access ends on the last counted cycle
  assign acc_end   = state_is(state, HTH_ACCESS) && (cnt == HTH_CNT_W'(HTH_ACCESS_CYC - 1));
  assign next_cnt  = state_is(state, HTH_ACCESS) ? cnt + 1'b1 : '0;

  // next-state decode feeding the registered pins
  assign next_access  = state_is(next_state, HTH_ACCESS);
  assign next_done    = state_is(next_state, HTH_DONE);
  assign next_release = state_is(next_state, HTH_RELEASE);
  assign next_busy    = next_access;

  // nonzero-wait ready: low in done only; zero-wait ready: low in access
  assign next_ready_n = zero_wait ? !next_access : !next_done;
  assign next_io_buffer_enable_n_n  = !(next_access || next_done);
  // drive read data in done, where nonzero-wait ready is low
  // the zero-wait host samples the bus as ready returns high,
  // so the drive window has to cover the release state as well
  assign next_d2h_oe  = is_read && (next_done || next_release);
  assign next_wr      = acc_end && !is_read;
  assign next_rd      = start && is_read;

  // ==========================================================
  // sequencing

  // next state
  always_comb begin
    next_state = state;
    case (state)
      HTH_IDLE:    if (start) next_state = HTH_ACCESS;
      HTH_ACCESS:  if (acc_end) next_state = zero_wait ? HTH_RELEASE : HTH_DONE;
      HTH_DONE:    if (strobe_n_s) next_state = HTH_IDLE;
      HTH_RELEASE: if (strobe_n_s) next_state = HTH_IDLE;
      default:     next_state = HTH_IDLE;
    endcase
  end

  // state and access counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= HTH_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // latch request at start: the synchronisers keep address, data
  // and select in step with the strobe, so one edge takes them all
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_addr    <= '0;
      reg_wdata   <= HTH_DATA_RST;
      reg_mem_sel <= 1'b0;
    end else if (start) begin
      reg_addr    <= addr_s;
      reg_wdata   <= data_s;
      reg_mem_sel <= sel_s;
    end
  end

  // access strobes to the user side: one-cycle pulses, so a strobe
  // held low past the access cannot repeat them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      busy   <= 1'b0;
    end else begin
      reg_wr <= next_wr;
      reg_rd <= next_rd;
      busy   <= next_busy;  // mirrors the access state
    end
  end

  // read data capture, held until the next read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= HTH_DATA_RST;
    end else if (acc_end && is_read) begin
      rdata_q <= reg_rdata;
    end
  end

  // ==========================================================
  // pin outputs

  // ready output: rests high in reset and between transfers; the
  // strap only chooses which state pulls it low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ready_n_q <= HTH_READY_N_RST;
    end else begin
      ready_n_q <= next_ready_n;
    end
  end

  // buffer enable and read drive; the enable spans done as well, so
  // external buffers stay open while the host still reads the word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      io_buffer_enable_n_n_q <= HTH_IO_BUFFER_ENABLE_N_N_RST;
      d2h_oe_q <= 1'b0;
    end else begin
      io_buffer_enable_n_n_q <= next_io_buffer_enable_n_n;
      d2h_oe_q <= next_d2h_oe;
    end
  end

  // pins come straight from the flip-flops above
  assign pins.host_ready_n       = ready_n_q;
  assign pins.io_buffer_enable_n = io_buffer_enable_n_n_q;
  assign pins.data_d2h           = rdata_q;
  assign pins.data_d2h_oe        = d2h_oe_q;
endmodule : hth_device
`default_nettype wire

// >>> rtl/hth_host.sv
// host end: drives strobe cycles and waits on ready
`timescale 1ns/1ps
`default_nettype none
module hth_host (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // pins
  hth_if.host                     pins,
  // user side
  input  wire logic               cfg_transparent,
  input  wire logic               req,
  input  wire logic               req_read,
  input  wire logic               req_mem,
  input  wire logic [hth_pkg::HTH_ADDR_W-1:0] req_addr,
  input  wire logic [hth_pkg::HTH_DATA_W-1:0] req_wdata,
  output logic                    req_ready,
  output logic                    done,
  output logic [hth_pkg::HTH_DATA_W-1:0] rdata,
  output logic                    buffers_open
);
  import hth_pkg::*;

  typedef enum logic [1:0] {HTH_H_IDLE, HTH_H_WAIT, HTH_H_REL} hth_host_state_t;

  hth_host_state_t         hstate;
  logic                    rdy_n_s;
  logic                    io_buffer_enable_n_n_s;
  logic [HTH_DATA_W-1:0]   bus_s;
  logic                    strb_n_q;
  logic                    rw_q;
  logic                    sel_q;
  logic [HTH_ADDR_W-1:0]   addr_q;
  logic [HTH_DATA_W-1:0]   wdata_q;
  logic                    mode_q;

  // ==========================================================
  // input synchronisation
  hth_sync #(.W(1), .RST(1'b1)) u_sync_rdy (
    .sys_clk(sys_clk), .srst(srst), .din(pins.host_ready_n), .dout(rdy_n_s));
  hth_sync #(.W(1), .RST(1'b1)) u_sync_io_buffer_enable_n (
    .sys_clk(sys_clk), .srst(srst), .din(pins.io_buffer_enable_n), .dout(io_buffer_enable_n_n_s));
  hth_sync #(.W(HTH_DATA_W), .RST('0)) u_sync_bus (
    .sys_clk(sys_clk), .srst(srst), .din(pins.data_bus), .dout(bus_s));

  // cycle sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hstate   <= HTH_H_IDLE;
      strb_n_q <= HTH_STROBE_RST;
      rw_q     <= 1'b1;
      sel_q    <= 1'b0;
      addr_q   <= '0;
      wdata_q  <= HTH_DATA_RST;
      done     <= 1'b0;
      rdata    <= HTH_DATA_RST;
    end else begin
      done <= 1'b0;
      case (hstate)
        HTH_H_IDLE: begin
          if (req && rdy_n_s) begin
            strb_n_q <= 1'b0;
            rw_q     <= req_read;
            sel_q    <= req_mem;
            addr_q   <= req_addr;
            wdata_q  <= req_wdata;
            hstate   <= HTH_H_WAIT;
          end
        end
        HTH_H_WAIT: begin
          if (!rdy_n_s) begin
            strb_n_q <= 1'b1;
            hstate   <= HTH_H_REL;
            if (mode_q) begin
              rdata <= bus_s;
              done  <= 1'b1;
            end
          end
        end
        HTH_H_REL: begin
          if (rdy_n_s) begin
            hstate <= HTH_H_IDLE;
            // zero-wait data valid once ready returns
            if (!mode_q) begin
              rdata <= bus_s;
              done  <= 1'b1;
            end
          end
        end
        default: hstate <= HTH_H_IDLE;
      endcase
    end
  end

  // strap and buffer gating
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q       <= 1'b0;
      buffers_open <= 1'b0;
      req_ready    <= 1'b0;
    end else begin
      mode_q       <= cfg_transparent;
      // open buffers in transparent mode only
      buffers_open <= mode_q && !io_buffer_enable_n_n_s;
      req_ready    <= (hstate == HTH_H_IDLE) && !req && rdy_n_s;
    end
  end

  assign pins.host_strobe_n    = strb_n_q;
  assign pins.rd_wr            = rw_q;
  assign pins.mem_reg_sel      = sel_q;
  assign pins.addr             = addr_q;
  assign pins.data_h2d         = wdata_q;
  assign pins.data_h2d_oe      = !strb_n_q && !rw_q;
  assign pins.transparent_mode = mode_q;
endmodule : hth_host
`default_nettype wire

// >>> bench/hth_monitor.sv
// checker: handshake relations on the host port pins
`timescale 1ns/1ps
`default_nettype none
module hth_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // pins
  input wire logic host_strobe_n,
  input wire logic host_ready_n,
  input wire logic io_buffer_enable_n,
  input wire logic rd_wr,
  input wire logic transparent_mode,
  input wire logic data_d2h_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ============================================================
  // handshake assertions
  a_idle_ready_high:
    assert property (!transparent_mode && io_buffer_enable_n && $past(io_buffer_enable_n)
      |-> host_ready_n) else $error("ready low while idle");
  a_zw_ready_len:
    assert property ($fell(host_ready_n) && !transparent_mode
      |-> !host_ready_n [*4] ##1 host_ready_n) else $error("zero wait ready length");
  a_ready_after_strobe:
    assert property ($fell(host_ready_n) |-> !host_strobe_n)
      else $error("ready low without strobe");
  a_nzw_read_data:
    assert property ($fell(host_ready_n) && transparent_mode && rd_wr |-> data_d2h_oe)
      else $error("read data not driven at ready");
  a_nzw_ready_hold:
    assert property (transparent_mode && !host_ready_n && !host_strobe_n |=> !host_ready_n)
      else $error("ready dropped while strobe low");
  a_ready_release:
    assert property (transparent_mode && $rose(host_strobe_n) && !host_ready_n
      |-> ##[1:4] host_ready_n) else $error("ready not released");
  a_io_buffer_enable_n_at_ready:
    assert property ($fell(host_ready_n) |-> !io_buffer_enable_n)
      else $error("buffer enable high during access");
  a_io_buffer_enable_n_cause:
    assert property ($fell(io_buffer_enable_n) |-> $past(!host_strobe_n, 2))
      else $error("buffer enable low without strobe");
  a_start_on_ready:
    assert property ($fell(host_strobe_n) |-> host_ready_n)
      else $error("strobe started while ready low");
  a_host_holds:
    assert property (transparent_mode && $rose(host_strobe_n) |-> !host_ready_n)
      else $error("strobe released before ready");
  // main scenarios
  c_zero_wait: cover property ($fell(host_ready_n) && !transparent_mode);
  c_nzw_read: cover property ($fell(host_ready_n) && transparent_mode && rd_wr);
  c_nzw_write: cover property ($fell(host_ready_n) && transparent_mode && !rd_wr);
endmodule // hth_monitor
`default_nettype wire

// >>> bench/host_transfer_handshake_test.sv
// testbench: host end and device end joined across the pin interface
`timescale 1ns/1ps
`default_nettype none
module host_transfer_handshake_test;
  import hth_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  cfg_transparent = 1'b0;
  logic                  req = 1'b0;
  logic                  req_read = 1'b0;
  logic                  req_mem = 1'b0;
  logic [HTH_ADDR_W-1:0] req_addr = 16'h0000;
  logic [HTH_DATA_W-1:0] req_wdata = 16'h0000;
  logic [HTH_DATA_W-1:0] reg_rdata = 16'h0000;
  logic                  req_ready, done, buffers_open, reg_wr, reg_rd, reg_mem_sel, busy;
  logic [HTH_DATA_W-1:0] rdata, reg_wdata, got_wdata;
  logic [HTH_ADDR_W-1:0] reg_addr, got_addr;
  logic                  got_mem;
  int                    n_fail = 0;
  int                    n_checks = 0;
  int                    n_pulse = 0;
  hth_if bus ();
  hth_device hth_device_i (.sys_clk(sys_clk), .srst(srst), .pins(bus), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_mem_sel(reg_mem_sel),
    .reg_rdata(reg_rdata), .busy(busy));
  hth_host hth_host_i (.sys_clk(sys_clk), .srst(srst), .pins(bus),
    .cfg_transparent(cfg_transparent), .req(req), .req_read(req_read), .req_mem(req_mem),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .done(done),
    .rdata(rdata), .buffers_open(buffers_open));
  hth_monitor hth_monitor_i (.sys_clk(sys_clk), .srst(srst),
    .host_strobe_n(bus.host_strobe_n), .host_ready_n(bus.host_ready_n),
    .io_buffer_enable_n(bus.io_buffer_enable_n), .rd_wr(bus.rd_wr),
    .transparent_mode(bus.transparent_mode), .data_d2h_oe(bus.data_d2h_oe));
  // clock
  always #12.5 sys_clk = ~sys_clk;
  // capture of device user-side strobes
  always @(negedge sys_clk) begin
    if (reg_wr === 1'b1 || reg_rd === 1'b1) begin
      n_pulse++;
      got_addr = reg_addr;
      got_wdata = reg_wdata;
      got_mem = reg_mem_sel;
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one word transfer, judged on both sides
  task automatic xfer(input logic rd, input logic mem, input logic [15:0] addr,
                      input logic [15:0] val);
    int k;
    int low;
    int opn;
    int nbusy;
    int base;
    logic seen;
    k = 0; low = 0; opn = 0; seen = 1'b0;
    nbusy = 0;
    base = n_pulse;
    req_read = rd; req_mem = mem; req_addr = addr; req_wdata = val; reg_rdata = val;
    while (req_ready !== 1'b1 && k < 100) begin @(negedge sys_clk); k++; end
    if (k == 100) begin n_fail++; close_out(); end
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    for (k = 0; k < 200; k++) begin
      @(negedge sys_clk);
      if (bus.host_ready_n === 1'b0) low++;
      if (buffers_open === 1'b1) opn++;
      if (busy === 1'b1) nbusy++;
      if (done === 1'b1) seen = 1'b1;
      if (seen && req_ready === 1'b1) break;
    end
    if (k == 200) begin n_fail++; close_out(); end
    if (rd) check("rdata", rdata, val);
    else check("wdata", got_wdata, val);
    check("addr", got_addr, addr);
    check("mem_sel", {15'h0000, got_mem}, {15'h0000, mem});
    check("pulses", 16'(n_pulse - base), 16'h0001);
    check("strap", {15'h0000, bus.transparent_mode}, {15'h0000, cfg_transparent});
    check("busy", 16'(nbusy), 16'(HTH_ACCESS_CYC));
    if (!cfg_transparent) check("zw_low", 16'(low), 16'(HTH_ACCESS_CYC));
    if (!cfg_transparent) check("closed", 16'(opn), 16'h0000);
    else check("open", 16'(opn != 0), 16'h0001);
  endtask
  task automatic sc_buffered();
    cfg_transparent = 1'b0;
    repeat (4) @(negedge sys_clk);
    xfer(1'b0, 1'b0, 16'h0012, 16'hA5C3);
    xfer(1'b1, 1'b1, 16'hFFFF, 16'h5A3C);
  endtask
  task automatic sc_transparent();
    cfg_transparent = 1'b1;
    repeat (4) @(negedge sys_clk);
    xfer(1'b1, 1'b0, 16'h0000, 16'h8001);
    xfer(1'b0, 1'b1, 16'h7FFE, 16'h0FF0);
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    repeat (3) @(negedge sys_clk);
    sc_buffered();
    sc_transparent();
    close_out();
  end
endmodule // host_transfer_handshake_test
`default_nettype wire
